// ---- core/mgi_irq.sv ----
// management interrupt status, enable and routing block with apb slave
//
// Our own choice: register access over APB.
`include "mgi_defs.svh"
`timescale 1ns/100ps
`default_nettype none

module mgi_irq
    import mgi_pkg::*;
(
    input  wire logic        pclk,                  // 250 MHz
    input  wire logic        presetn,               // async, low
    input  wire logic        psel,                  // apb select
    input  wire logic        penable,               // apb enable
    input  wire logic        pwrite,                // apb direction
    input  wire logic [7:0]  paddr,                 // apb byte address
    input  wire logic [31:0] pwdata,                // apb write data
    input  wire logic [3:0]  pstrb,                 // apb byte strobes
    output logic      [31:0] prdata,                // apb read data
    output logic             pready,                // apb ready
    output logic             pslverr,               // apb error
    input  wire mgi_src_s    src,                   // interrupt sources
    output logic             group_mgmt_request_n,  // group request, low
    output logic             mgmt_request_pin_n,    // dedicated pin, low
    output logic             serirq_slot_req,       // serial irq slot request
    output logic             pme_req,               // into power-event logic
    output logic             irq                    // software interrupt
);

    mgi_state_s s_r;
    mgi_state_s s_nxt;
    logic [7:0] sts1_v;
    logic [7:0] sts2_v;
    logic       grp_v;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic [5:0] idx_of(input logic [7:0] a);
        return a[7:2];
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        logic [5:0] i;
        i = idx_of(a);
        return (a[1:0] == 2'h0) &&
               (((i >= `MGI_IDX_STS1) && (i <= `MGI_IDX_RSVB)) ||
                (i == `MGI_IDX_IRQ_STS) || (i == `MGI_IDX_IRQ_MSK));
    endfunction

    // ****************************************
    // live status views and group term
    // ****************************************
    always_comb
    begin
        sts1_v = {2'h0, src.lvl1, 1'b0};
        sts2_v = {3'h0, s_r.p92_flag, 1'b0, s_r.ir_flag, src.lvl2};
        grp_v  = |(sts1_v & s_r.en1 & `MGI_EN1_MASK)
               | |(sts2_v & s_r.en2 & `MGI_EN2_SRC)
               | |(s_r.sts3 & s_r.en3 & `MGI_EN3_MASK)
               | |(s_r.sts4 & s_r.en4 & `MGI_EN4_MASK)
               | |(s_r.sts5 & s_r.en5 & `MGI_EN5_MASK);
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        logic       setup;
        logic       acc;
        logic       wr;
        logic [5:0] i;
        logic [7:0] d;
        logic [7:0] rd;
        setup = psel && !penable;
        acc   = psel && penable && s_r.rdy;
        wr    = acc && pwrite && !s_r.err && pstrb[0];
        i     = idx_of(paddr);
        d     = pwdata[7:0];
        rd    = 8'h00;
        s_nxt = s_r;

        // write-one clears first, so a same-cycle event below wins
        if (wr)
        begin
            case (i)
                `MGI_IDX_STS2:    s_nxt.p92_flag = s_r.p92_flag & ~d[`MGI_BIT_P92];
                `MGI_IDX_STS3:    s_nxt.sts3 = s_r.sts3 & ~d;
                `MGI_IDX_STS4:    s_nxt.sts4 = s_r.sts4 & ~d;
                `MGI_IDX_STS5:    s_nxt.sts5 = s_r.sts5 & ~d;
                `MGI_IDX_EN1:     s_nxt.en1 = d & `MGI_EN1_MASK;
                `MGI_IDX_EN2:     s_nxt.en2 = d & `MGI_EN2_MASK;
                `MGI_IDX_EN3:     s_nxt.en3 = d & `MGI_EN3_MASK;
                `MGI_IDX_EN4:     s_nxt.en4 = d & `MGI_EN4_MASK;
                `MGI_IDX_EN5:     s_nxt.en5 = d & `MGI_EN5_MASK;
                `MGI_IDX_IRQ_STS: s_nxt.ev_sts = s_r.ev_sts & ~d[1:0];
                `MGI_IDX_IRQ_MSK: s_nxt.ev_msk = d[1:0];
                default:          s_nxt.ev_msk = s_nxt.ev_msk;
            endcase
        end
        // reading status two consumes the infrared flag
        if (acc && !pwrite && !s_r.err && (i == `MGI_IDX_STS2))
        begin
            s_nxt.ir_flag = 1'b0;
        end

        // event capture, after clears so that set wins
        s_nxt.sts3 = s_nxt.sts3 | (src.gp3 & `MGI_EN3_MASK);
        s_nxt.sts4 = s_nxt.sts4 | src.gp4;
        s_nxt.sts5 = s_nxt.sts5 | (src.gp5 & `MGI_EN5_MASK);
        s_nxt.ir_prev = src.ir_rx;
        if (src.ir_rx != s_r.ir_prev)
        begin
            s_nxt.ir_flag = 1'b1;
        end
        if (src.port92)
        begin
            s_nxt.p92_flag = 1'b1;
        end

        // group request and its three routes
        s_nxt.grp_n = !grp_v;
        s_nxt.pme   = grp_v && s_r.en2[`MGI_BIT_PME];
        s_nxt.seri  = grp_v && s_r.en2[`MGI_BIT_SERI];
        s_nxt.pin_n = !(grp_v && s_r.en2[`MGI_BIT_PIN]);

        // software interrupt on group edges
        if (grp_v && s_r.grp_n)
        begin
            s_nxt.ev_sts[`MGI_EV_RISE] = 1'b1;
        end
        if (!grp_v && !s_r.grp_n)
        begin
            s_nxt.ev_sts[`MGI_EV_FALL] = 1'b1;
        end
        s_nxt.irq = |(s_r.ev_sts & s_r.ev_msk);

        // apb: data captured in setup, ready in the first access cycle
        case (i)
            `MGI_IDX_STS1:    rd = sts1_v;
            `MGI_IDX_STS2:    rd = sts2_v;
            `MGI_IDX_STS3:    rd = s_r.sts3;
            `MGI_IDX_STS4:    rd = s_r.sts4;
            `MGI_IDX_STS5:    rd = s_r.sts5;
            `MGI_IDX_EN1:     rd = s_r.en1;
            `MGI_IDX_EN2:     rd = s_r.en2;
            `MGI_IDX_EN3:     rd = s_r.en3;
            `MGI_IDX_EN4:     rd = s_r.en4;
            `MGI_IDX_EN5:     rd = s_r.en5;
            `MGI_IDX_IRQ_STS: rd = {6'h00, s_r.ev_sts};
            `MGI_IDX_IRQ_MSK: rd = {6'h00, s_r.ev_msk};
            default:          rd = 8'h00;
        endcase
        s_nxt.rdy = setup;
        if (setup)
        begin
            s_nxt.rdata = mapped(paddr) ? rd : 8'h00;
            s_nxt.err   = !mapped(paddr);
        end
        else if (acc)
        begin
            s_nxt.rdata = 8'h00;
            s_nxt.err   = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r       <= '0;
            s_r.grp_n <= 1'b1;
            s_r.pin_n <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign prdata               = {24'h000000, s_r.rdata};
    assign pready               = s_r.rdy;
    assign pslverr              = s_r.err;
    assign group_mgmt_request_n = s_r.grp_n;
    assign mgmt_request_pin_n   = s_r.pin_n;
    assign serirq_slot_req      = s_r.seri;
    assign pme_req              = s_r.pme;
    assign irq                  = s_r.irq;

    // ****************************************
    // checks
    // ****************************************
    a_grp_tracks: assert property (@(posedge pclk) disable iff (!presetn)
        group_mgmt_request_n == !$past(grp_v)) else $error("group request wrong");
    a_pme_route: assert property (@(posedge pclk) disable iff (!presetn)
        pme_req |-> !group_mgmt_request_n) else $error("pme without group");
    a_seri_route: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(s_r.en2[`MGI_BIT_SERI]) && !group_mgmt_request_n) |-> serirq_slot_req)
        else $error("serial slot missed");
    a_pin_route: assert property (@(posedge pclk) disable iff (!presetn)
        !mgmt_request_pin_n |-> ($past(s_r.en2[`MGI_BIT_PIN]) && !group_mgmt_request_n))
        else $error("pin driven wrongly");
    a_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && (paddr[7:2] == `MGI_IDX_RSVA || paddr[7:2] == `MGI_IDX_RSVB))
        |=> (prdata == 32'h00000000) && pready) else $error("reserved reads nonzero");
    a_sts5_set: assert property (@(posedge pclk) disable iff (!presetn)
        src.gp5[7] |=> s_r.sts5[7]) else $error("fan event lost");
    a_sts5_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.sts5[0] && !(psel && penable && pwrite)) |=> s_r.sts5[0])
        else $error("status five dropped");
    a_ir_set: assert property (@(posedge pclk) disable iff (!presetn)
        (src.ir_rx != s_r.ir_prev) |=> s_r.ir_flag) else $error("ir edge lost");
    a_en_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.en3[3] && !s_r.en5[4] && !s_r.en5[5] && !s_r.en1[0]) else $error("reserved set");
    a_en4_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && !pslverr
         && paddr[7:2] == `MGI_IDX_EN4) |=> (s_r.en4 == $past(pwdata[7:0])))
        else $error("enable four not stored");
    a_p92_set: assert property (@(posedge pclk) disable iff (!presetn)
        src.port92 |=> s_r.p92_flag) else $error("port92 lost");

    // ****************************************
    // register and route checks
    // ****************************************
    a_pme_off: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(s_r.en2[`MGI_BIT_PME]) |-> !pme_req)
        else $error("pme routed while disabled");
    a_pme_on: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(s_r.en2[`MGI_BIT_PME]) && !group_mgmt_request_n) |-> pme_req)
        else $error("pme route missed");
    a_seri_off: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(s_r.en2[`MGI_BIT_SERI]) |-> !serirq_slot_req)
        else $error("serial slot while disabled");
    a_pin_on: assert property (@(posedge pclk) disable iff (!presetn)
        ($past(s_r.en2[`MGI_BIT_PIN]) && !group_mgmt_request_n) |-> !mgmt_request_pin_n)
        else $error("pin route missed");
    a_en1_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        ((s_r.en1 & ~`MGI_EN1_MASK) == 8'h00))
        else $error("enable one reserved set");
    a_en2_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.en2[3])
        else $error("enable two reserved set");
    a_sts5_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.sts5[5:4] == 2'h0))
        else $error("status five reserved set");
    a_sts3_rsvd: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.sts3[3])
        else $error("status three reserved set");
    a_sts5_w1c: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && !pslverr
         && paddr[7:2] == `MGI_IDX_STS5 && src.gp5 == 8'h00)
        |=> (s_r.sts5 == ($past(s_r.sts5) & ~$past(pwdata[7:0])))) else $error("sts5 clear");
    a_en1_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && !pslverr
         && paddr[7:2] == `MGI_IDX_EN1)
        |=> (s_r.en1 == ($past(pwdata[7:0]) & `MGI_EN1_MASK))) else $error("en1 not stored");
    a_en2_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && !pslverr
         && paddr[7:2] == `MGI_IDX_EN2)
        |=> (s_r.en2 == ($past(pwdata[7:0]) & `MGI_EN2_MASK))) else $error("en2 not stored");
    a_en3_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && !pslverr
         && paddr[7:2] == `MGI_IDX_EN3)
        |=> (s_r.en3 == ($past(pwdata[7:0]) & `MGI_EN3_MASK))) else $error("en3 not stored");
    a_en5_wr: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && !pslverr
         && paddr[7:2] == `MGI_IDX_EN5)
        |=> (s_r.en5 == ($past(pwdata[7:0]) & `MGI_EN5_MASK))) else $error("en5 not stored");
    a_fan_set: assert property (@(posedge pclk) disable iff (!presetn)
        src.gp5[6] |=> s_r.sts5[6])
        else $error("fan one event lost");
    a_sts3_set: assert property (@(posedge pclk) disable iff (!presetn)
        src.gp3[7] |=> s_r.sts3[7])
        else $error("status three event lost");
    a_sts4_set: assert property (@(posedge pclk) disable iff (!presetn)
        src.gp4[0] |=> s_r.sts4[0])
        else $error("status four event lost");
    a_sts1_live: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && paddr == {`MGI_IDX_STS1, 2'h0})
        |=> (prdata[7:0] == {2'h0, $past(src.lvl1), 1'b0}))
        else $error("status one not live");
    a_ir_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.ir_flag && !(psel && penable && !pwrite)) |=> s_r.ir_flag)
        else $error("ir flag dropped");
    a_ir_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && !pwrite && !pslverr
         && paddr[7:2] == `MGI_IDX_STS2 && src.ir_rx == s_r.ir_prev)
        |=> !s_r.ir_flag) else $error("ir flag not cleared by read");
    a_p92_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.p92_flag && !(psel && penable && pwrite)) |=> s_r.p92_flag)
        else $error("port92 flag dropped");
    a_p92_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && pstrb[0] && !pslverr && pwdata[4]
         && paddr[7:2] == `MGI_IDX_STS2 && !src.port92)
        |=> !s_r.p92_flag) else $error("port92 flag not cleared");
    a_irq_off: assert property (@(posedge pclk) disable iff (!presetn)
        (s_r.ev_msk == 2'h0) |=> !irq)
        else $error("irq while masked");
    a_err_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> (prdata == 32'h00000000))
        else $error("error read nonzero");

endmodule

`default_nettype wire

// ---- core/mgi_defs.svh ----
// register indices, field masks, reset values of the management irq block
`ifndef MGI_DEFS_SVH
`define MGI_DEFS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define MGI_IDX_STS1    6'h10
`define MGI_IDX_STS2    6'h11
`define MGI_IDX_STS3    6'h12
`define MGI_IDX_STS4    6'h13
`define MGI_IDX_STS5    6'h14
`define MGI_IDX_RSVA    6'h15
`define MGI_IDX_EN1     6'h16
`define MGI_IDX_EN2     6'h17
`define MGI_IDX_EN3     6'h18
`define MGI_IDX_EN4     6'h19
`define MGI_IDX_EN5     6'h1A
`define MGI_IDX_RSVB    6'h1B
`define MGI_IDX_IRQ_STS 6'h20
`define MGI_IDX_IRQ_MSK 6'h21

// ****************************************
// implemented bits and field positions
// ****************************************
`define MGI_EN1_MASK    8'h3E
`define MGI_EN2_SRC     8'h17
`define MGI_EN2_MASK    8'hF7
`define MGI_EN3_MASK    8'hF7
`define MGI_EN4_MASK    8'hFF
`define MGI_EN5_MASK    8'hCF
`define MGI_BIT_PME     5
`define MGI_BIT_SERI    6
`define MGI_BIT_PIN     7
`define MGI_BIT_IR      2
`define MGI_BIT_P92     4
`define MGI_EV_RISE     0
`define MGI_EV_FALL     1

// ****************************************
// reset values
// ****************************************
`define MGI_RST_BYTE    8'h00
`define MGI_RST_EV      2'h0

`endif

// ---- core/mgi_pkg.sv ----
// types shared by the management irq block
package mgi_pkg;

    // source inputs, one bundle
    typedef struct packed {
        logic [4:0] lvl1;   // midi,floppy,serial1,serial2,parallel (bits 5..1)
        logic [1:0] lvl2;   // keyboard, mouse
        logic       ir_rx;  // selected infrared receive input
        logic       port92; // port-92 event level
        logic [7:0] gp3;    // pin events, status three layout
        logic [7:0] gp4;    // pin events, status four layout
        logic [7:0] gp5;    // pin and fan events, status five layout
    } mgi_src_s;

    typedef struct packed {
        logic [7:0] sts3;
        logic [7:0] sts4;
        logic [7:0] sts5;
        logic       ir_flag;
        logic       p92_flag;
        logic       ir_prev;
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] en3;
        logic [7:0] en4;
        logic [7:0] en5;
        logic [1:0] ev_sts;
        logic [1:0] ev_msk;
        logic       grp_n;
        logic       pin_n;
        logic       seri;
        logic       pme;
        logic       irq;
        logic [7:0] rdata;
        logic       rdy;
        logic       err;
    } mgi_state_s;

endpackage

// ---- sim/mgi_host_model.sv ----
// host-side receiver model that counts requests on the dedicated pin
`timescale 1ns/100ps
`default_nettype none

module mgi_host_model
(
    input  wire logic       pclk,      // bus clock
    input  wire logic       presetn,   // async, low
    input  wire logic       pin_n,     // dedicated request pin, low
    output logic      [7:0] pin_hits   // falling edges seen
);
    logic pin_q;

    // the host latches on the falling edge only, so a held level counts once
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q    <= 1'b1;
            pin_hits <= 8'h00;
        end
        else
        begin
            pin_q <= pin_n;
            if (pin_q && !pin_n)
                pin_hits <= pin_hits + 8'h01;
        end
    end
endmodule

`default_nettype wire

// ---- sim/mgi_irq_bench.sv ----
// self-checking bench of the management irq block
`timescale 1ns/100ps
`default_nettype none
`include "mgi_defs.svh"

module mgi_irq_bench import mgi_pkg::*;;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00, hits;
    logic [31:0] pwdata = 32'h0, prdata, rd, r;
    logic [3:0]  pstrb = 4'hF;
    logic        pready, pslverr, grp_n, pin_n, seri, pme, irq, er;
    mgi_src_s    src = '0;
    logic [31:0] seed = 32'ha36c;
    logic [7:0]  msk [0:4] = '{`MGI_EN1_MASK, `MGI_EN2_MASK, `MGI_EN3_MASK,
                               `MGI_EN4_MASK, `MGI_EN5_MASK};
    logic [7:0]  smk [0:2] = '{8'hF7, 8'hFF, 8'hCF};
    int          n_fail = 0, checks_done = 0, hit_exp = 0, j;

    always #2 pclk = ~pclk;

    mgi_irq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src(src),
        .group_mgmt_request_n(grp_n), .mgmt_request_pin_n(pin_n),
        .serirq_slot_req(seri), .pme_req(pme), .irq(irq));

    mgi_host_model host_u (.pclk(pclk), .presetn(presetn), .pin_n(pin_n),
        .pin_hits(hits));

    // ****************************************
    // shared tasks
    // ****************************************
    task test_done;
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e)
        begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask

    // one apb transfer; answer taken only at the edge where pready is high
    task apb(input logic w, input logic [5:0] idx, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {idx, 2'h0};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 16; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 16)
        begin
            n_fail++;
            test_done;
        end
    endtask

    task wr(input logic [5:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask

    task rdc(input logic [5:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 32'h0);
        chk(rd, e);
    endtask

    task wt(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (j = `MGI_IDX_STS5; j <= `MGI_IDX_RSVB; j++)
            rdc(6'(j), 32'h0);
        wr(`MGI_IDX_RSVA, 32'hFF);
        wr(`MGI_IDX_RSVB, 32'hFF);
        rdc(`MGI_IDX_RSVA, 32'h0);
        rdc(`MGI_IDX_RSVB, 32'h0);
        rdc(6'h3F, 32'h0);
        chk(er, 1'b1);
        $display("test reset done");
        for (j = 0; j < 5; j++)
        begin
            r = xs();
            wr(6'(`MGI_IDX_EN1 + j), r);
            rdc(6'(`MGI_IDX_EN1 + j), r[7:0] & msk[j]);
            wr(6'(`MGI_IDX_EN1 + j), 32'h0);
        end
        pstrb <= 4'h0;
        wr(`MGI_IDX_EN2, 32'hFF);
        pstrb <= 4'hF;
        rdc(`MGI_IDX_EN2, 32'h0);
        $display("test enables done");
        for (j = 0; j < 3; j++)
        begin
            @(posedge pclk);
            {src.gp3, src.gp4, src.gp5} <= 24'hFF << (8 * (2 - j));
            @(posedge pclk);
            {src.gp3, src.gp4, src.gp5} <= 24'h0;
            rdc(6'(`MGI_IDX_STS3 + j), smk[j]);
            wr(6'(`MGI_IDX_STS3 + j), 32'h01);
            rdc(6'(`MGI_IDX_STS3 + j), smk[j] & 8'hFE);
            wr(6'(`MGI_IDX_EN3 + j), 32'h80);
            wt(3);
            chk(grp_n, 1'b0);
            wr(6'(`MGI_IDX_EN3 + j), 32'h0);
            wt(3);
            chk(grp_n, 1'b1);
            wr(6'(`MGI_IDX_STS3 + j), 32'hFF);
            rdc(6'(`MGI_IDX_STS3 + j), 32'h0);
        end
        $display("test sticky done");
        wr(`MGI_IDX_IRQ_STS, 32'h3);
        wr(`MGI_IDX_IRQ_MSK, 32'h1);
        @(posedge pclk);
        src.lvl1 <= 5'h01;
        rdc(`MGI_IDX_STS1, 32'h02);
        wr(`MGI_IDX_STS1, 32'hFF);
        rdc(`MGI_IDX_STS1, 32'h02);
        wr(`MGI_IDX_EN1, 32'h02);
        wt(3);
        chk(grp_n, 1'b0);
        chk(irq, 1'b1);
        for (j = 0; j < 8; j++)
        begin
            wr(`MGI_IDX_EN2, j << 5);
            wt(3);
            hit_exp += (j == 4);
            chk(pme, j[0]);
            chk(seri, j[1]);
            chk(pin_n, !j[2]);
        end
        chk(hits, hit_exp);
        wr(`MGI_IDX_IRQ_MSK, 32'h0);
        wt(2);
        chk(irq, 1'b0);
        @(posedge pclk);
        src.lvl1 <= 5'h00;
        wt(3);
        chk(grp_n, 1'b1);
        rdc(`MGI_IDX_IRQ_STS, 32'h3);
        wr(`MGI_IDX_IRQ_STS, 32'h3);
        rdc(`MGI_IDX_IRQ_STS, 32'h0);
        wr(`MGI_IDX_EN2, 32'h0);
        wr(`MGI_IDX_EN1, 32'h0);
        $display("test routing done");
        @(posedge pclk);
        src.ir_rx <= 1'b1;
        rdc(`MGI_IDX_STS2, 32'h04);
        rdc(`MGI_IDX_STS2, 32'h00);
        @(posedge pclk);
        src.port92 <= 1'b1;
        @(posedge pclk);
        src.port92 <= 1'b0;
        wr(`MGI_IDX_EN2, 32'h10);
        wt(3);
        chk(grp_n, 1'b0);
        rdc(`MGI_IDX_STS2, 32'h10);
        wr(`MGI_IDX_STS2, 32'h10);
        wt(3);
        chk(grp_n, 1'b1);
        rdc(`MGI_IDX_STS2, 32'h0);
        $display("test infrared done");
        test_done;
    end
endmodule

`default_nettype wire
